// >>> flash_cmd_pkg.sv
/*
  Constants and carrier types for the lock and reset command slice.
  Assumes a 25 MHz system clock sampling the serial link pins.
*/
package flash_cmd_pkg;
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam logic [7:0] OP_GLOBAL_LOCK = 8'h7E;
  localparam logic [7:0] OP_GLOBAL_UNLOCK = 8'h98;
  localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
  localparam logic [7:0] OP_RESET = 8'h99;
  localparam int unsigned RECOVERY_US = 30;
  localparam int unsigned RECOVERY_CYCLES = RECOVERY_US * (CLK_HZ / 1_000_000);
  localparam int unsigned SELECT_DELAY_US = 20;
  localparam int unsigned SELECT_DELAY_CYCLES =
    SELECT_DELAY_US * (CLK_HZ / 1_000_000);
  localparam int unsigned WRITE_DELAY_MS = 5;
  localparam int unsigned WRITE_DELAY_CYCLES =
    WRITE_DELAY_MS * (CLK_HZ / 1_000);
  localparam int unsigned OPCODE_BITS = 8;
  localparam int unsigned LOCK_COUNT_DEFAULT = 16;
  localparam logic LOCK_RESET_VALUE = 1'b1;
  localparam logic [7:0] READ_PARAM_RESET = 8'h00;
  localparam logic [7:0] CONT_READ_RESET = 8'h00;
  localparam logic [2:0] WRAP_RESET = 3'h7;

  // One decoded instruction, valid for one cycle after select rises
  typedef struct packed {
    logic valid;
    logic [7:0] opcode;
  } opcode_event_t;

  // Volatile settings that a reset discards
  typedef struct packed {
    logic write_enable_latch;
    logic suspend_flag;
    logic [7:0] read_param_bits;
    logic [7:0] cont_read_mode_bits;
    logic [2:0] wrap_bits;
  } volatile_state_t;
endpackage

// >>> flash_host_model.sv
/*
  Serial host: frames opcodes on select, link clock and data.
  Assumes the device samples these pins asynchronously.
*/
`timescale 1ns/1ns
module flash_host_model (
  output logic select_n,
  output logic link_clk,
  output logic serial_in
);
  initial begin
    select_n = 1'b1;
    link_clk = 1'b0;
    serial_in = 1'b0;
  end
  // Clock idles low between frames; idle data flips so no stale bit
  task automatic send(input logic [8:0] bits, input int n);
    select_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      serial_in = bits[i];
      #160 link_clk = 1'b1;
      #160 link_clk = 1'b0;
    end
    #160 select_n = 1'b1;
    serial_in = ~serial_in;
  endtask
endmodule

// >>> flash_lock_reset_commands.sv
/*
  Lock and software reset command slice of a serial flash.
  Decodes global lock/unlock and the enable-then-reset pair, keeps the
  volatile lock bits and settings, and times recovery and power-up.
  Assumes link pins arrive asynchronously and are sampled at 25 MHz.
*/
// Summary of operation
// - Global lock opcode 7E sets every lock bit to one.
// - Global unlock opcode 98 clears every lock bit to zero.
// - Accepted reset aborts internal operation, returns to power-on state.
// - Reset discards volatile status, latch, suspend, param, mode, wrap.
// - Reset happens only when 66 is directly followed by 99.
// - Any instruction other than 66 or 99 after 66 disarms the reset enable.
// - About 30 us recovery after reset; all instructions ignored meanwhile.
// - Write instructions held off until 5 ms after power-up.
// - Lock bits are volatile and read one after power-up or reset.
// - Lock bits protect only when scheme select is one.
`timescale 1ns/1ns
module flash_lock_reset_commands #(
  parameter int unsigned LOCK_COUNT = flash_cmd_pkg::LOCK_COUNT_DEFAULT,
  parameter int unsigned RECOVERY_CYCLES = flash_cmd_pkg::RECOVERY_CYCLES,
  parameter int unsigned WRITE_DELAY_CYCLES =
    flash_cmd_pkg::WRITE_DELAY_CYCLES
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic select_n_pin,
  input wire logic link_clk_pin,
  input wire logic serial_in_pin,
  input wire logic lock_scheme_select,
  input wire logic [LOCK_COUNT-1:0] legacy_protect,
  input wire logic set_write_enable,
  input wire logic set_suspend,
  input wire logic internal_busy,
  input wire logic [7:0] read_param_in,
  input wire logic read_param_load,
  input wire logic [7:0] cont_read_in,
  input wire logic cont_read_load,
  input wire logic [2:0] wrap_in,
  input wire logic wrap_load,
  output logic [LOCK_COUNT-1:0] lock_bits,
  output logic [LOCK_COUNT-1:0] protect_map,
  output flash_cmd_pkg::volatile_state_t volatile_state,
  output logic abort_operation,
  output logic recovering,
  output logic reset_armed,
  output logic select_allowed,
  output logic write_allowed
);
  localparam int unsigned RCW = $clog2(RECOVERY_CYCLES + 1);
  localparam int unsigned WDW = $clog2(WRITE_DELAY_CYCLES + 1);
  localparam int unsigned SDW =
    $clog2(flash_cmd_pkg::SELECT_DELAY_CYCLES + 1);

  // Two-stage synchronisers; first stage feeds only the second
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic link_clk_prev_reg;
  logic link_clk_rise;
  flash_cmd_pkg::opcode_event_t opcode_event;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      // Idle pin levels: select high, link clock low, so no false edge
      sync1_reg <= 3'h5;
      sync2_reg <= 3'h5;
      link_clk_prev_reg <= 1'b0;
    end else begin
      sync1_reg <= {select_n_pin, link_clk_pin, serial_in_pin};
      sync2_reg <= sync1_reg;
      link_clk_prev_reg <= sync2_reg[1];
    end
  end

  assign link_clk_rise = sync2_reg[1] && !link_clk_prev_reg;

  opcode_shifter shifter (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .select_n(sync2_reg[2]),
    .link_clk_rise(link_clk_rise),
    .serial_in(sync2_reg[0]),
    .opcode_event(opcode_event)
  );

  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_RECOVER} cmd_state_t;

  cmd_state_t state_reg;
  cmd_state_t state_next;
  logic [RCW-1:0] rec_cnt_reg;
  logic [RCW-1:0] rec_cnt_next;
  logic [LOCK_COUNT-1:0] lock_reg;
  logic [LOCK_COUNT-1:0] lock_next;
  flash_cmd_pkg::volatile_state_t vol_reg;
  flash_cmd_pkg::volatile_state_t vol_next;
  logic abort_reg;
  logic abort_next;
  logic [LOCK_COUNT-1:0] prot_reg;
  logic [LOCK_COUNT-1:0] prot_next;
  logic do_reset;
  logic [7:0] op;
  logic recovering_reg;
  logic recovering_next;
  logic armed_reg;
  logic armed_next;

  always_comb begin
    state_next = state_reg;
    rec_cnt_next = rec_cnt_reg;
    lock_next = lock_reg;
    vol_next = vol_reg;
    abort_next = 1'b0;
    do_reset = 1'b0;
    op = opcode_event.opcode;
    if (set_write_enable) begin
      vol_next.write_enable_latch = 1'b1;
    end
    if (set_suspend) begin
      vol_next.suspend_flag = 1'b1;
    end
    if (read_param_load) begin
      vol_next.read_param_bits = read_param_in;
    end
    if (cont_read_load) begin
      vol_next.cont_read_mode_bits = cont_read_in;
    end
    if (wrap_load) begin
      vol_next.wrap_bits = wrap_in;
    end
    unique case (state_reg)
      ST_IDLE, ST_ARMED: begin
        if (opcode_event.valid) begin
          state_next = ST_IDLE;
          if (op == flash_cmd_pkg::OP_RESET_ENABLE) begin
            state_next = ST_ARMED;
          end else if (op == flash_cmd_pkg::OP_RESET &&
                       state_reg == ST_ARMED) begin
            do_reset = 1'b1;
          end else if (op == flash_cmd_pkg::OP_GLOBAL_LOCK) begin
            lock_next = '1;
          end else if (op == flash_cmd_pkg::OP_GLOBAL_UNLOCK) begin
            lock_next = '0;
          end
        end
      end
      ST_RECOVER: begin
        // Instructions are dropped until the count runs out
        if (rec_cnt_reg == RCW'(1)) begin
          state_next = ST_IDLE;
        end
        rec_cnt_next = rec_cnt_reg - RCW'(1);
      end
    endcase
    if (do_reset) begin
      state_next = ST_RECOVER;
      rec_cnt_next = RCW'(RECOVERY_CYCLES);
      abort_next = 1'b1;
      lock_next = {LOCK_COUNT{flash_cmd_pkg::LOCK_RESET_VALUE}};
      vol_next.write_enable_latch = 1'b0;
      vol_next.suspend_flag = 1'b0;
      vol_next.read_param_bits = flash_cmd_pkg::READ_PARAM_RESET;
      vol_next.cont_read_mode_bits = flash_cmd_pkg::CONT_READ_RESET;
      vol_next.wrap_bits = flash_cmd_pkg::WRAP_RESET;
    end
    // Scheme select picks lock bits or the legacy protect fields
    prot_next = lock_scheme_select ? lock_next : legacy_protect;
    recovering_next = (state_next == ST_RECOVER);
    armed_next = (state_next == ST_ARMED);
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      rec_cnt_reg <= '0;
      lock_reg <= {LOCK_COUNT{flash_cmd_pkg::LOCK_RESET_VALUE}};
      vol_reg <= '{1'b0, 1'b0, flash_cmd_pkg::READ_PARAM_RESET,
                  flash_cmd_pkg::CONT_READ_RESET, flash_cmd_pkg::WRAP_RESET};
      abort_reg <= 1'b0;
      prot_reg <= '0;
      recovering_reg <= 1'b0;
      armed_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      rec_cnt_reg <= rec_cnt_next;
      lock_reg <= lock_next;
      vol_reg <= vol_next;
      abort_reg <= abort_next;
      prot_reg <= prot_next;
      recovering_reg <= recovering_next;
      armed_reg <= armed_next;
    end
  end

  // Power-up timers; sys_rst stands in for supply reaching its minimum
  logic [WDW-1:0] wdelay_reg;
  logic [WDW-1:0] wdelay_next;
  logic [SDW-1:0] sdelay_reg;
  logic [SDW-1:0] sdelay_next;
  logic write_ok_reg;
  logic write_ok_next;
  logic select_ok_reg;
  logic select_ok_next;

  always_comb begin
    wdelay_next = wdelay_reg;
    sdelay_next = sdelay_reg;
    if (wdelay_reg != WDW'(WRITE_DELAY_CYCLES)) begin
      wdelay_next = wdelay_reg + WDW'(1);
    end
    if (sdelay_reg != SDW'(flash_cmd_pkg::SELECT_DELAY_CYCLES)) begin
      sdelay_next = sdelay_reg + SDW'(1);
    end
    // Writes also stay blocked while recovering from a reset
    write_ok_next = (wdelay_next == WDW'(WRITE_DELAY_CYCLES)) &&
                    (state_next != ST_RECOVER);
    select_ok_next =
      (sdelay_next == SDW'(flash_cmd_pkg::SELECT_DELAY_CYCLES));
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wdelay_reg <= '0;
      sdelay_reg <= '0;
      write_ok_reg <= 1'b0;
      select_ok_reg <= 1'b0;
    end else begin
      wdelay_reg <= wdelay_next;
      sdelay_reg <= sdelay_next;
      write_ok_reg <= write_ok_next;
      select_ok_reg <= select_ok_next;
    end
  end

  assign lock_bits = lock_reg;
  assign protect_map = prot_reg;
  assign volatile_state = vol_reg;
  assign abort_operation = abort_reg;
  assign recovering = recovering_reg;
  assign reset_armed = armed_reg;
  assign select_allowed = select_ok_reg;
  assign write_allowed = write_ok_reg;
endmodule

// >>> flash_lock_reset_commands_monitor.sv
/*
  Port assertions for the lock and reset command slice.
  Assumes one ref_clk domain with synchronous active-high sys_rst.
*/
`timescale 1ns/1ns
module flash_lock_reset_commands_monitor #(
  parameter int unsigned LOCK_COUNT = 16,
  parameter int unsigned RECOVERY_CYCLES = 750,
  parameter int unsigned WRITE_DELAY_CYCLES = 125000
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic lock_scheme_select,
  input wire logic [LOCK_COUNT-1:0] legacy_protect,
  input wire logic [LOCK_COUNT-1:0] lock_bits,
  input wire logic [LOCK_COUNT-1:0] protect_map,
  input wire flash_cmd_pkg::volatile_state_t volatile_state,
  input wire logic abort_operation,
  input wire logic recovering,
  input wire logic reset_armed,
  input wire logic select_allowed,
  input wire logic write_allowed
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic [31:0] up_reg, up_next, rec_reg, rec_next;
  always_comb begin
    up_next = (up_reg == 32'hFFFFFFFF) ? up_reg : up_reg + 32'h1;
    rec_next = recovering ? rec_reg + 32'h1 : 32'h0;
  end
  always_ff @(posedge ref_clk) begin
    up_reg <= sys_rst ? 32'h0 : up_next;
    rec_reg <= sys_rst ? 32'h0 : rec_next;
  end
  sequence s_accept;
    abort_operation ##1 !abort_operation;
  endsequence
  sequence s_cleared;
    ##[0:2] (&lock_bits && !reset_armed && recovering);
  endsequence
  AST_ABORT_PULSE: assert property (abort_operation |-> s_accept)
    else $error("abort longer than one cycle");
  AST_ARMED_FIRST: assert property (abort_operation |-> $past(reset_armed))
    else $error("reset accepted without enable");
  AST_LOCKS_SET: assert property (abort_operation |-> s_cleared)
    else $error("reset left locks or arm state");
  AST_VOL_CLEAR: assert property (abort_operation |-> ##[0:2]
    (volatile_state.wrap_bits == flash_cmd_pkg::WRAP_RESET &&
     volatile_state.read_param_bits == flash_cmd_pkg::READ_PARAM_RESET &&
     !volatile_state.write_enable_latch && !volatile_state.suspend_flag))
    else $error("volatile settings survived reset");
  AST_REC_LEN: assert property ($fell(recovering) |->
    rec_reg inside {[RECOVERY_CYCLES-1:RECOVERY_CYCLES+1]})
    else $error("recovery length wrong");
  AST_REC_HOLD: assert property (recovering && $past(recovering)
    |-> $stable(lock_bits)) else $error("locks changed in recovery");
  AST_MAP: assert property (!$past(sys_rst) |-> protect_map ==
    ($past(lock_scheme_select) ? lock_bits : $past(legacy_protect)))
    else $error("protect map wrong source");
  AST_WRITE: assert property ((write_allowed |-> !recovering &&
    up_reg >= WRITE_DELAY_CYCLES - 2) and
    (up_reg >= WRITE_DELAY_CYCLES + 2 && !recovering [*2] |-> write_allowed))
    else $error("write gate wrong");
  AST_SELECT: assert property ((select_allowed |-> up_reg >= 498) and
    (up_reg >= 502 |-> select_allowed)) else $error("select gate wrong");
endmodule
bind flash_lock_reset_commands flash_lock_reset_commands_monitor #(
  .LOCK_COUNT(LOCK_COUNT), .RECOVERY_CYCLES(RECOVERY_CYCLES),
  .WRITE_DELAY_CYCLES(WRITE_DELAY_CYCLES)) mon_i (.ref_clk(ref_clk),
  .sys_rst(sys_rst), .lock_scheme_select(lock_scheme_select),
  .legacy_protect(legacy_protect), .lock_bits(lock_bits),
  .protect_map(protect_map), .volatile_state(volatile_state),
  .abort_operation(abort_operation), .recovering(recovering),
  .reset_armed(reset_armed), .select_allowed(select_allowed),
  .write_allowed(write_allowed));

// >>> opcode_shifter.sv
/*
  Serial opcode receiver: shifts serial_in on rising link clock edges
  while select is low and reports the byte when select rises.
  Assumes select, link clock and data are already synchronised to ref_clk.
*/
`timescale 1ns/1ns
module opcode_shifter (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic select_n,
  input wire logic link_clk_rise,
  input wire logic serial_in,
  output flash_cmd_pkg::opcode_event_t opcode_event
);
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic [4:0] count_reg;
  logic [4:0] count_next;
  logic select_prev_reg;
  flash_cmd_pkg::opcode_event_t event_reg;
  flash_cmd_pkg::opcode_event_t event_next;

  always_comb begin
    shift_next = shift_reg;
    count_next = count_reg;
    event_next = '0;
    if (select_n) begin
      count_next = 5'h00;
      // Exactly eight bits, then select high; anything else is ignored
      if (!select_prev_reg &&
          count_reg == 5'(flash_cmd_pkg::OPCODE_BITS)) begin
        event_next.valid = 1'b1;
        event_next.opcode = shift_reg;
      end
    end else if (link_clk_rise) begin
      shift_next = {shift_reg[6:0], serial_in};
      // Saturate so long frames never wrap back to eight
      if (count_reg != 5'h1F) begin
        count_next = count_reg + 5'h01;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      shift_reg <= 8'h00;
      count_reg <= 5'h00;
      select_prev_reg <= 1'b1;
      event_reg <= '0;
    end else begin
      shift_reg <= shift_next;
      count_reg <= count_next;
      select_prev_reg <= select_n;
      event_reg <= event_next;
    end
  end

  assign opcode_event = event_reg;
endmodule

// >>> tb.sv
/*
  Self-checking bench for the lock and reset command slice.
  Assumes the host model and the bound port monitor.
*/
`timescale 1ns/1ns
module tb;
  logic ref_clk = 1'b0, sys_rst = 1'b1, scheme = 1'b0, set_we = 1'b0;
  logic set_sus = 1'b0, p_ld = 1'b0, m_ld = 1'b0, w_ld = 1'b0;
  logic select_n, link_clk, serial_in, abort_op, recovering, armed;
  logic sel_ok, wr_ok;
  logic [15:0] legacy = 16'h0, locks, lock_bits, protect_map;
  logic [7:0] p_in = 8'h0, m_in = 8'h0, op;
  logic [2:0] w_in = 3'h0;
  logic [31:0] seed = 32'h0000E615;
  flash_cmd_pkg::volatile_state_t vol;
  int fail_count = 0, comparisons = 0, cycles = 0;
  flash_host_model flash_host_model_i (.select_n(select_n),
    .link_clk(link_clk), .serial_in(serial_in));
  // Short recovery still outlasts one frame so refusal can be seen
  flash_lock_reset_commands #(.LOCK_COUNT(16), .RECOVERY_CYCLES(200),
    .WRITE_DELAY_CYCLES(50)) flash_lock_reset_commands_i (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .select_n_pin(select_n),
    .link_clk_pin(link_clk), .serial_in_pin(serial_in),
    .lock_scheme_select(scheme), .legacy_protect(legacy),
    .set_write_enable(set_we), .set_suspend(set_sus), .internal_busy(1'b0),
    .read_param_in(p_in), .read_param_load(p_ld), .cont_read_in(m_in),
    .cont_read_load(m_ld), .wrap_in(w_in), .wrap_load(w_ld),
    .lock_bits(lock_bits), .protect_map(protect_map), .volatile_state(vol),
    .abort_operation(abort_op), .recovering(recovering),
    .reset_armed(armed), .select_allowed(sel_ok), .write_allowed(wr_ok));
  initial forever #20 ref_clk = ~ref_clk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic [15:0] want_locks(input logic [7:0] o,
      input logic [15:0] cur);
    if (o == flash_cmd_pkg::OP_GLOBAL_LOCK) return 16'hFFFF;
    if (o == flash_cmd_pkg::OP_GLOBAL_UNLOCK) return 16'h0000;
    return cur;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      fail_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic print_verdict;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic frame(input logic [8:0] bits, input int n);
    flash_host_model_i.send(bits, n);
    repeat (8) @(negedge ref_clk);
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 8000) begin
      fail_count++;
      print_verdict();
    end
  end
  initial begin
    repeat (2) @(negedge ref_clk);
    sys_rst = 1'b0;
    check(32'(lock_bits), 32'h0000FFFF);
    check(32'(vol), 32'h00000007);
    check(32'(wr_ok), 32'h0);
    for (int i = 0; i < 600 && sel_ok !== 1'b1; i++) @(negedge ref_clk);
    check(32'(sel_ok), 32'h1);
    // Two reset edges precede the power-up count
    check(32'(cycles), flash_cmd_pkg::SELECT_DELAY_CYCLES + 2);
    check(32'(wr_ok), 32'h1);
    $display("test power-up done");
    locks = 16'hFFFF;
    frame({flash_cmd_pkg::OP_GLOBAL_UNLOCK, 1'b0}, 9);
    check(32'(lock_bits), 32'(locks));
    for (int i = 0; i < 10; i++) begin
      seed = xs(seed);
      op = seed[0] ? flash_cmd_pkg::OP_GLOBAL_LOCK :
        flash_cmd_pkg::OP_GLOBAL_UNLOCK;
      scheme = seed[1];
      legacy = seed[31:16];
      frame({1'b0, op}, (seed[2] || i < 2) ? 8 : 7);
      if (seed[2] || i < 2) locks = want_locks(op, locks);
      check(32'(lock_bits), 32'(locks));
      check(32'(protect_map), 32'(scheme ? locks : legacy));
    end
    $display("test lock and unlock done");
    frame({1'b0, flash_cmd_pkg::OP_RESET_ENABLE}, 8);
    check(32'(armed), 32'h1);
    frame({1'b0, flash_cmd_pkg::OP_GLOBAL_UNLOCK}, 8);
    check(32'(armed), 32'h0);
    frame({1'b0, flash_cmd_pkg::OP_RESET}, 8);
    check(32'({recovering, lock_bits}), 32'h0);
    $display("test disarm done");
    seed = xs(seed);
    {p_in, m_in, w_in} = seed[18:0];
    {set_we, set_sus, p_ld, m_ld, w_ld} = 5'h1F;
    @(negedge ref_clk);
    {set_we, set_sus, p_ld, m_ld, w_ld} = 5'h00;
    check(32'(vol), {11'h0, 2'h3, seed[18:0]});
    // Busy is never raised here; suspend set on purpose to see it cleared
    frame({1'b0, flash_cmd_pkg::OP_RESET_ENABLE}, 8);
    frame({1'b0, flash_cmd_pkg::OP_RESET}, 8);
    check(32'({recovering, wr_ok, lock_bits}), 32'h0002FFFF);
    check(32'(vol), 32'h00000007);
    frame({1'b0, flash_cmd_pkg::OP_GLOBAL_UNLOCK}, 8);
    for (int i = 0; i < 300 && recovering !== 1'b0; i++) @(negedge ref_clk);
    check(32'({recovering, lock_bits}), 32'h0000FFFF);
    frame({1'b0, flash_cmd_pkg::OP_GLOBAL_UNLOCK}, 8);
    check(32'(lock_bits), 32'h0);
    $display("test software reset done");
    print_verdict();
  end
endmodule
